// *** pkg/usart_defs.vh ***
// constants for the serial port block: offsets, fields, resets, timing
`ifndef USART_DEFS_VH
`define USART_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define USART_OFS_RXCTL   3'h0
`define USART_OFS_RXBUF   3'h1
`define USART_OFS_TXCTL   3'h2
`define USART_OFS_TXBUF   3'h3
`define USART_OFS_BAUD    3'h4
`define USART_OFS_FLAG    3'h5
`define USART_OFS_IEN     3'h6

// ------------------------------------------------------------
// receive status and control fields
// ------------------------------------------------------------
`define USART_RX_PEN      7
`define USART_RX_NINE     6
`define USART_RX_SINGLE   5
`define USART_RX_CONT     4
`define USART_RX_ADDR     3
`define USART_RX_FRAMING_ERROR_FLAG     2
`define USART_RX_OVERRUN_ERROR_FLAG     1
`define USART_RX_NINTH    0

// ------------------------------------------------------------
// transmit status and control fields
// ------------------------------------------------------------
`define USART_TX_CLOCK_SOURCE_SELECT     7
`define USART_TX_NINE     6
`define USART_TX_EN       5
`define USART_TX_SYNC     4
`define USART_TX_HIGH     2
`define USART_TX_EMPTY    1
`define USART_TX_NINTH    0

// ------------------------------------------------------------
// flag and enable fields
// ------------------------------------------------------------
`define USART_FLG_RX      5
`define USART_FLG_TX      4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define USART_RST_RXCTL   8'h00
`define USART_RST_TXCTL   8'h02
`define USART_RST_BYTE    8'h00

// ------------------------------------------------------------
// timing counts, in oversample ticks; the slow-rate prescaler count is in divisor ticks
// ------------------------------------------------------------
`define USART_OVS_LAST    4'hF
`define USART_OVS_DECIDE  4'h9
`define USART_HALF_LAST   3'h7
`define USART_LOW_PRESC   2'h3

`endif

// *** hw/usart_baud_gen.v ***
// baud generator: divisor counter and 16x oversample tick
`timescale 1ns/1ps
`include "usart_defs.vh"

module usart_baud_gen (
  input  wire       clk,
  input  wire       resetn,
  input  wire       enable,
  input  wire [7:0] divisor,
  input  wire       highSpeed,
  output reg        tick
);

  reg  [7:0] count;
  reg  [1:0] presc;
  wire       brgTick;

  assign brgTick = enable && (count == 8'h00);

  // ------------------------------------------------------------
  // divisor count, then /4 when the slow rate is chosen
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      presc <= 2'h0;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= 8'h00;
      presc <= 2'h0;
      tick  <= 1'b0;
    end else begin
      count <= brgTick ? divisor : count - 8'h01;
      if (brgTick) begin
        presc <= presc + 2'h1;
      end
      // raw rate is 16x or 64x bit rate; out is always 16x
      tick <= brgTick && (highSpeed || presc == `USART_LOW_PRESC);
    end
  end

endmodule

// *** hw/usart_core.v ***
// serial port: async receiver and synchronous master transmitter
`timescale 1ns/1ps
`include "usart_defs.vh"


module usart_core (
  input  wire       clk,
  input  wire       resetn,
  input  wire [2:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdata,
  input  wire       dataLineIn,
  output wire       dataLineOut,
  output wire       dataLineOe,
  output wire       shiftClockLineOut,
  output wire       shiftClockLineOe,
  output wire       rxIrq,
  output wire       txIrq
);

  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA  = 2'd2;
  localparam RX_STOP  = 2'd3;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  reg  [7:0] rxCtl;
  reg  [7:0] txCtl;
  reg  [7:0] rxBuf;
  reg  [7:0] txBuf;
  reg  [7:0] baudDiv;
  reg        rxIe;
  reg        txIe;
  reg        rxFlag;
  reg        txFlag;
  reg        txBufFull;
  reg        txWrPending;
  reg        rxNinth;
  reg        frameErr;
  reg        overErr;

  wire portEn    = rxCtl[`USART_RX_PEN];
  wire rxNine    = rxCtl[`USART_RX_NINE];
  wire contRx    = rxCtl[`USART_RX_CONT];
  wire addrDet   = rxCtl[`USART_RX_ADDR];
  wire clkMaster = txCtl[`USART_TX_CLOCK_SOURCE_SELECT];
  wire txNine    = txCtl[`USART_TX_NINE];
  wire transmit_enable      = txCtl[`USART_TX_EN];
  wire syncMode  = txCtl[`USART_TX_SYNC];
  wire highSpeed = txCtl[`USART_TX_HIGH];
  wire txNinth   = txCtl[`USART_TX_NINTH];

  wire wrRxCtl = regWr && regAddr == `USART_OFS_RXCTL;
  wire wrTxCtl = regWr && regAddr == `USART_OFS_TXCTL;
  wire wrTxBuf = regWr && regAddr == `USART_OFS_TXBUF;
  wire wrBaud  = regWr && regAddr == `USART_OFS_BAUD;
  wire wrIen   = regWr && regAddr == `USART_OFS_IEN;
  wire rdRxBuf = regRd && regAddr == `USART_OFS_RXBUF;

  // ------------------------------------------------------------
  // pin synchroniser and oversample tick
  // ------------------------------------------------------------
  reg  dataSync1;
  reg  dataSync2;
  wire tick;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataSync1 <= 1'b1;
      dataSync2 <= 1'b1;
    end else begin
      dataSync1 <= dataLineIn;
      dataSync2 <= dataSync1;
    end
  end

  usart_baud_gen baudGen (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (portEn),
    .divisor   (baudDiv),
    .highSpeed (highSpeed),
    .tick      (tick)
  );

  // ------------------------------------------------------------
  // async receiver
  // ------------------------------------------------------------
  reg  [1:0] rxState;
  reg  [3:0] ovsCnt;
  reg  [3:0] bitCnt;
  reg  [2:0] sampleHist;
  reg  [8:0] rxShift;
  wire       rxOn;
  wire       voteBit;
  wire       decide;
  wire [3:0] lastBit;
  wire       wordDone;
  wire       keepWord;
  wire       bufBusy;
  reg        txBusy;

  // transmit path owns the line in sync mode
  assign rxOn = portEn && contRx && !syncMode && !overErr && !txBusy;
  // majority of three samples around mid bit rejects glitches
  assign voteBit = (sampleHist[0] & sampleHist[1]) | (sampleHist[1] & sampleHist[2]) |
                   (sampleHist[0] & sampleHist[2]);
  assign decide   = tick && ovsCnt == `USART_OVS_DECIDE;
  assign lastBit  = rxNine ? 4'h8 : 4'h7;
  assign wordDone = decide && rxState == RX_STOP;
  assign keepWord = !(addrDet && rxNine && !rxShift[8]);
  assign bufBusy  = rxFlag && !rdRxBuf;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState    <= RX_IDLE;
      ovsCnt     <= 4'h0;
      bitCnt     <= 4'h0;
      sampleHist <= 3'h7;
      rxShift    <= 9'h000;
    end else if (!rxOn) begin
      rxState    <= RX_IDLE;
      ovsCnt     <= 4'h0;
      bitCnt     <= 4'h0;
    end else begin
      if (tick) begin
        sampleHist <= {sampleHist[1:0], dataSync2};
        ovsCnt     <= ovsCnt + 4'h1;
      end
      case (rxState)
        RX_IDLE: begin
          if (tick && !dataSync2) begin
            rxState <= RX_START;
            ovsCnt  <= 4'h1;
          end
        end
        RX_START: begin
          if (decide) begin
            rxState <= voteBit ? RX_IDLE : RX_DATA;
            bitCnt  <= 4'h0;
          end
        end
        RX_DATA: begin
          if (decide) begin
            rxShift[bitCnt] <= voteBit;
            rxShift[8]      <= (bitCnt == 4'h8) ? voteBit : (rxNine ? rxShift[8] : 1'b0);
            bitCnt          <= bitCnt + 4'h1;
            if (bitCnt == lastBit) begin
              rxState <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (decide) begin
            rxState <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive buffer, flag and errors
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxBuf    <= `USART_RST_BYTE;
      rxNinth  <= 1'b0;
      rxFlag   <= 1'b0;
      frameErr <= 1'b0;
      overErr  <= 1'b0;
    end else begin
      if (rdRxBuf) begin
        rxFlag <= 1'b0;
      end
      if (!contRx) begin
        frameErr <= 1'b0;
        overErr  <= 1'b0;
      end else if (wordDone && keepWord) begin
        if (bufBusy) begin
          overErr <= 1'b1;
        end else begin
          rxBuf    <= rxShift[7:0];
          rxNinth  <= rxNine & rxShift[8];
          frameErr <= !voteBit;
          rxFlag   <= 1'b1;
        end
      end
    end
  end

  assign rxIrq = rxFlag && rxIe;

  // ------------------------------------------------------------
  // sync master transmitter
  // ------------------------------------------------------------
  reg  [8:0] transmit_shift_register;
  reg  [3:0] bitsLeft;
  reg        tsrEmpty;
  reg        shiftClk;
  reg  [2:0] halfCnt;
  wire       txOn;
  wire       loadTsr;
  wire       halfDone;

  assign txOn     = portEn && syncMode && clkMaster && transmit_enable;
  // never start while a word is being received
  assign loadTsr  = txOn && tsrEmpty && txBufFull && rxState == RX_IDLE;
  assign halfDone = tick && halfCnt == `USART_HALF_LAST;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      transmit_shift_register      <= 9'h1FF;
      bitsLeft <= 4'h0;
      tsrEmpty <= 1'b1;
      shiftClk <= 1'b0;
      halfCnt  <= 3'h0;
      txBusy   <= 1'b0;
    end else if (!txOn) begin
      tsrEmpty <= 1'b1;
      shiftClk <= 1'b0;
      halfCnt  <= 3'h0;
      bitsLeft <= 4'h0;
      txBusy   <= 1'b0;
    end else if (loadTsr) begin
      transmit_shift_register      <= {txNinth, txBuf};
      bitsLeft <= txNine ? 4'h9 : 4'h8;
      tsrEmpty <= 1'b0;
      shiftClk <= 1'b0;
      halfCnt  <= 3'h0;
      txBusy   <= 1'b1;
    end else if (!tsrEmpty) begin
      if (tick) begin
        halfCnt <= halfCnt + 3'h1;
      end
      if (halfDone) begin
        shiftClk <= !shiftClk;
        // data moves on the falling edge, peer samples on the rising
        if (shiftClk) begin
          if (bitsLeft == 4'h1) begin
            tsrEmpty <= 1'b1;
            txBusy   <= 1'b0;
            bitsLeft <= 4'h0;
          end else begin
            transmit_shift_register      <= {1'b1, transmit_shift_register[8:1]};
            bitsLeft <= bitsLeft - 4'h1;
          end
        end
      end
    end
  end

  assign shiftClockLineOut = shiftClk;
  assign shiftClockLineOe  = portEn && syncMode && clkMaster;
  assign dataLineOut       = transmit_shift_register[0];
  assign dataLineOe        = txOn && rxState == RX_IDLE;

  // ------------------------------------------------------------
  // transmit buffer and flag
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txBuf       <= `USART_RST_BYTE;
      txBufFull   <= 1'b0;
      txWrPending <= 1'b0;
      txFlag      <= 1'b0;
    end else begin
      txWrPending <= wrTxBuf;
      if (wrTxBuf) begin
        txBuf     <= regWdata;
        txBufFull <= 1'b1;
      end else if (loadTsr) begin
        txBufFull <= 1'b0;
      end
      // a set beats the delayed clear in the same cycle
      if (loadTsr || (transmit_enable && !txBufFull && !txWrPending)) begin
        txFlag <= 1'b1;
      end else if (txWrPending) begin
        txFlag <= 1'b0;
      end
    end
  end

  assign txIrq = txFlag && txIe;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxCtl   <= `USART_RST_RXCTL;
      txCtl   <= `USART_RST_TXCTL;
      baudDiv <= `USART_RST_BYTE;
      rxIe    <= 1'b0;
      txIe    <= 1'b0;
    end else begin
      if (wrRxCtl) begin
        // error and ninth-bit fields are status, kept apart
        rxCtl <= {regWdata[7:3], 3'h0};
      end
      if (wrTxCtl) begin
        txCtl <= {regWdata[7:4], 1'b0, regWdata[2], 1'b0, regWdata[0]};
      end
      if (wrBaud) begin
        baudDiv <= regWdata;
      end
      if (wrIen) begin
        rxIe <= regWdata[`USART_FLG_RX];
        txIe <= regWdata[`USART_FLG_TX];
      end
    end
  end

  // ------------------------------------------------------------
  // register reads, one cycle after the strobe
  // ------------------------------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (regAddr)
      `USART_OFS_RXCTL: next_rdata = {rxCtl[7:3], frameErr, overErr, rxNinth};
      `USART_OFS_RXBUF: next_rdata = rxBuf;
      `USART_OFS_TXCTL: next_rdata = {txCtl[7:4], 1'b0, txCtl[2], tsrEmpty, txCtl[0]};
      `USART_OFS_TXBUF: next_rdata = txBuf;
      `USART_OFS_BAUD:  next_rdata = baudDiv;
      `USART_OFS_FLAG:  next_rdata = {2'h0, rxFlag, txFlag, 4'h0};
      `USART_OFS_IEN:   next_rdata = {2'h0, rxIe, txIe, 4'h0};
      default:          next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// *** verification/usart_core_checker.sv ***
// assertions on the serial port's bus and pins
`timescale 1ns/1ps
`include "usart_defs.vh"

module usart_core_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [2:0] regAddr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       dataLineOut,
  input wire logic       dataLineOe,
  input wire logic       shiftClockLineOut,
  input wire logic       shiftClockLineOe,
  input wire logic       rxIrq,
  input wire logic       txIrq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RD_IDLE: assert property (
    !regRd |=> regRdata == 8'h00) else $error("read data not zero");
  AST_UNMAPPED: assert property (
    regRd && regAddr == 3'h7 |=> regRdata == 8'h00) else $error("unmapped read not zero");
  AST_RX_FLAG: assert property (
    regRd && regAddr == `USART_OFS_FLAG && rxIrq |=> regRdata[5]) else $error("rx flag lost");
  AST_TX_FLAG: assert property (
    regRd && regAddr == `USART_OFS_FLAG && txIrq |=> regRdata[4]) else $error("tx flag lost");
  AST_RX_READ: assert property (
    regRd && regAddr == `USART_OFS_RXBUF |=> !rxIrq) else $error("rx request kept after read");
  AST_BUSY: assert property (
    regRd && regAddr == `USART_OFS_TXCTL && shiftClockLineOut |=> !regRdata[1])
    else $error("shifter empty while clocking");
  AST_CLK_HIGH: assert property (
    $rose(shiftClockLineOut) |-> shiftClockLineOut[*8]) else $error("clock high too short");
  AST_CLK_LOW: assert property (
    $fell(shiftClockLineOut) |-> !shiftClockLineOut[*8]) else $error("clock low too short");
  AST_CLK_DRIVEN: assert property (
    shiftClockLineOut |-> shiftClockLineOe && dataLineOe) else $error("clock without drive");
  AST_DATA_HOLD: assert property (
    shiftClockLineOut && $past(shiftClockLineOut) |-> $stable(dataLineOut))
    else $error("data moved while clock high");
endmodule

bind usart_core usart_core_checker u_chk (
  .clk              (clk),
  .resetn           (resetn),
  .regAddr          (regAddr),
  .regRd            (regRd),
  .regRdata         (regRdata),
  .dataLineOut      (dataLineOut),
  .dataLineOe       (dataLineOe),
  .shiftClockLineOut(shiftClockLineOut),
  .shiftClockLineOe (shiftClockLineOe),
  .rxIrq            (rxIrq),
  .txIrq            (txIrq)
);

// *** verification/usart_peer.sv ***
// far-side serial peer: async sender, sync receiver
`timescale 1ns/1ps

module usart_peer #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic dataLineOut,
  input  wire logic dataLineOe,
  input  wire logic shiftClockLineOut,
  output logic      lineOut
);
  logic [8:0] got;
  int         cnt;

  // async line idles high, as with a pull-up
  initial begin
    lineOut = 1'b1;
    got = 9'h000;
    cnt = 0;
  end

  // start, n data bits lsb first, stop, one idle bit
  task automatic send(input logic [8:0] w, input int n, input logic stopBit);
    lineOut <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      lineOut <= w[i];
      repeat (BIT) @(posedge clk);
    end
    lineOut <= stopBit;
    repeat (BIT) @(posedge clk);
    lineOut <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask

  // sample on the rising shift clock, lsb first
  always @(posedge shiftClockLineOut) begin
    if (dataLineOe) begin
      got <= {dataLineOut, got[8:1]};
      cnt <= cnt + 1;
    end
  end
endmodule

// *** verification/test_usart_async_rx_sync_master_tx.sv ***
// self-checking bench for the serial port block
`timescale 1ns/1ps
`include "usart_defs.vh"

module test_usart_async_rx_sync_master_tx;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdata;
  logic       peerLine;
  wire        dataLineOut;
  wire        dataLineOe;
  wire        shiftClockLineOut;
  wire        shiftClockLineOe;
  wire        rxIrq;
  wire        txIrq;
  int         error_cnt = 0;
  int         checked = 0;
  int         base;
  int         waited;

  // device drive wins; otherwise the peer's line
  wire dataLineIn = dataLineOe ? dataLineOut : peerLine;

  always #10 clk = ~clk;

  usart_core dut (
    .clk              (clk),
    .resetn           (resetn),
    .regAddr          (regAddr),
    .regWdata         (regWdata),
    .regWr            (regWr),
    .regRd            (regRd),
    .regRdata         (regRdata),
    .dataLineIn       (dataLineIn),
    .dataLineOut      (dataLineOut),
    .dataLineOe       (dataLineOe),
    .shiftClockLineOut(shiftClockLineOut),
    .shiftClockLineOe (shiftClockLineOe),
    .rxIrq            (rxIrq),
    .txIrq            (txIrq)
  );

  // divisor 1 at high speed: 2 clocks a tick, 32 a bit
  usart_peer #(.BIT(32)) peer (
    .clk              (clk),
    .dataLineOut      (dataLineOut),
    .dataLineOe       (dataLineOe),
    .shiftClockLineOut(shiftClockLineOut),
    .lineOut          (peerLine)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task rdchk(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(name, {1'b0, exp}, {1'b0, regRdata});
  endtask

  // bounded wait for the peer's bit count; clocks spent kept in waited
  task waitcnt(input int n);
    waited = 0;
    while (peer.cnt < n && waited < 3000) begin
      @(posedge clk);
      waited++;
    end
    if (peer.cnt < n) begin
      error_cnt++;
      $display("MISMATCH peer bits expected %0d seen %0d", n, peer.cnt);
    end
  endtask

  task stop_test;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    rdchk(`USART_OFS_RXCTL, 8'h00, "rxctl");
    rdchk(`USART_OFS_TXCTL, 8'h02, "txctl");
    rdchk(`USART_OFS_RXBUF, 8'h00, "rxbuf");
    rdchk(3'h7, 8'h00, "unmapped");
    wr(`USART_OFS_BAUD, 8'h01);
    rdchk(`USART_OFS_BAUD, 8'h01, "baud");
  endtask

  task t_rx8;
    wr(`USART_OFS_TXCTL, 8'h04);
    wr(`USART_OFS_IEN, 8'h20);
    wr(`USART_OFS_RXCTL, 8'h80);
    peer.send(9'h011, 8, 1'b1);
    #1 chk("rxIrq idle", 9'h0, {8'h00, rxIrq});
    wr(`USART_OFS_RXCTL, 8'h90);
    peer.send(9'h0A5, 8, 1'b1);
    #1 chk("rxIrq", 9'h1, {8'h00, rxIrq});
    rdchk(`USART_OFS_FLAG, 8'h20, "rx flag");
    rdchk(`USART_OFS_RXBUF, 8'hA5, "rxbuf");
    chk("rxIrq read", 9'h0, {8'h00, rxIrq});
  endtask

  task t_err;
    peer.send(9'h077, 8, 1'b0);
    rdchk(`USART_OFS_RXCTL, 8'h94, "framing");
    rdchk(`USART_OFS_RXBUF, 8'h77, "rxbuf");
    peer.send(9'h0E1, 8, 1'b1);
    peer.send(9'h01E, 8, 1'b1);
    rdchk(`USART_OFS_RXCTL, 8'h92, "overrun");
    rdchk(`USART_OFS_RXBUF, 8'hE1, "kept word");
    wr(`USART_OFS_RXCTL, 8'h80);
    rdchk(`USART_OFS_RXCTL, 8'h80, "errors cleared");
  endtask

  task t_addr;
    wr(`USART_OFS_RXCTL, 8'hC8);
    wr(`USART_OFS_RXCTL, 8'hD8);
    peer.send(9'h033, 9, 1'b1);
    #1 chk("data dropped", 9'h0, {8'h00, rxIrq});
    peer.send(9'h15A, 9, 1'b1);
    #1 chk("address taken", 9'h1, {8'h00, rxIrq});
    rdchk(`USART_OFS_RXCTL, 8'hD9, "ninth");
    rdchk(`USART_OFS_RXBUF, 8'h5A, "address");
  endtask

  task t_tx;
    wr(`USART_OFS_RXCTL, 8'h80);
    wr(`USART_OFS_TXCTL, 8'hF5);
    rdchk(`USART_OFS_TXCTL, 8'hF7, "txctl");
    rdchk(`USART_OFS_FLAG, 8'h10, "tx flag");
    wr(`USART_OFS_IEN, 8'h10);
    #1 chk("txIrq", 9'h1, {8'h00, txIrq});
    base = peer.cnt;
    wr(`USART_OFS_TXBUF, 8'h3C);
    wr(`USART_OFS_TXBUF, 8'hC3);
    rdchk(`USART_OFS_FLAG, 8'h00, "flag full");
    wr(`USART_OFS_FLAG, 8'hFF);
    rdchk(`USART_OFS_FLAG, 8'h00, "flag ro");
    // land the next read inside the first high half of the shift clock
    repeat (12) @(posedge clk);
    rdchk(`USART_OFS_TXCTL, 8'hF5, "busy");
    chk("txIrq full", 9'h0, {8'h00, txIrq});
    waitcnt(base + 9);
    chk("word1", 9'h13C, peer.got);
    waitcnt(base + 18);
    chk("word2", 9'h1C3, peer.got);
    repeat (100) @(posedge clk);
    rdchk(`USART_OFS_TXCTL, 8'hF7, "empty");
    rdchk(`USART_OFS_FLAG, 8'h10, "flag empty");
    wr(`USART_OFS_IEN, 8'h00);
    #1 chk("txIrq masked", 9'h0, {8'h00, txIrq});
  endtask

  // eight-bit word at the slow rate: 8 clocks a tick, 128 a bit
  task t_slow;
    wr(`USART_OFS_TXCTL, 8'hB1);
    base = peer.cnt;
    wr(`USART_OFS_TXBUF, 8'h96);
    waitcnt(base + 8);
    chk("word3", {1'b0, 8'h96}, {1'b0, peer.got[8:1]});
    chk("slow rate", 9'h1, {8'h00, waited > 900 && waited < 1000});
    repeat (100) @(posedge clk);
    chk("bits sent", 9'h008, 9'(peer.cnt - base));
  endtask

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rx8();
    t_err();
    t_addr();
    t_tx();
    t_slow();
    stop_test();
  end

  // the run needs about 4300 clocks
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
